// ### hw/lcf_consts.vh
// constants for the led channel fade control block
`ifndef LCF_CONSTS_VH
`define LCF_CONSTS_VH
`define LCF_CLK_HZ          40000000
`define LCF_DEB_TIME_US     20000
`define LCF_FADE_STEP_US    10000
`define LCF_PWM_HZ          220
`define LCF_PWM_RES         256
`define LCF_FADE_STEPS      63
`define LCF_ADDR_FADE_STEP  8'h00
`define LCF_ADDR_STATUS     8'h04
`define LCF_ADDR_INT_STATUS 8'h08
`define LCF_ADDR_INT_CLEAR  8'h0C
`define LCF_ADDR_INT_ENABLE 8'h10
`define LCF_INT_ENABLE_RST  4'h0
`define LCF_RESP_OKAY       2'h0
`define LCF_RESP_SLVERR     2'h2
`define LCF_IN_SW_A         0
`define LCF_IN_SW_B         1
`define LCF_IN_BACKLIGHT    2
`define LCF_IN_SOURCE       3
`define LCF_IN_STYLE        4
`define LCF_IN_POLARITY     5
`define LCF_IN_DIM          6
`define LCF_IN_COUNT        7
`define LCF_EV_TARGET_A     0
`define LCF_EV_TARGET_B     1
`define LCF_EV_FAULT        2
`define LCF_EV_RAMP_DONE    3
`endif

// ### hw/lcf_top.v
// led channel fade control: enables, fade ramps, dimming, fault and register slave
// How it works
// - pulse mode: each low-going switch pulse toggles that main channel on or off.
// - level mode: main channel on while its switch input high, off while low.
// - backlight input is deglitched; backlight output follows its level.
// - pulse mode debounces each switch input and latches the channel state.
// - turn-on ramps brightness to full through 63 gamma-corrected steps.
// - trigger while on ramps brightness down to zero through the same steps.
// - a new trigger mid-ramp abandons the ramp and reverses toward the new target.
// - internal dim mode: switch enable state on overrides whatever the dim input requests.
// - external dim mode gates both main outputs directly with the dim input.
// - internal dim mode: active dim level triggers the built-in fading source.
// - built-in source is a gamma-corrected pwm repeating at 220 hz.
// - dim input polarity selectable active-high or active-low.
// - open-drain fault output pulled low on string short or thermal shutdown.
// - source select high picks external dim, low internal; it is deglitched.
// - style select high picks pulse mode, low picks level mode.
// - polarity select high makes dim input active-high, low active-low.
// - grounded fade-up timing input gives instant full brightness.
`timescale 1ns/1ps
`include "lcf_consts.vh"
module lcf_top #(
    parameter DEB_CYCLES  = (`LCF_CLK_HZ / 1000000) * `LCF_DEB_TIME_US,
    parameter FADE_CYCLES = (`LCF_CLK_HZ / 1000000) * `LCF_FADE_STEP_US,
    parameter CNT_W       = 20
) (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire        switch_input_a,
    input  wire        switch_input_b,
    input  wire        backlight_on_input,
    input  wire        dim_input,
    input  wire        dim_source_select,
    input  wire        switch_style_select,
    input  wire        dim_polarity_select,
    input  wire        fade_up_timing,
    input  wire        fade_down_timing,
    input  wire        string_short_detect,
    input  wire        thermal_shutdown,
    output reg         lamp_output_a,
    output reg         lamp_output_b,
    output reg         backlight_output,
    input  wire        fault_report_n_in,
    output wire        fault_report_n_out,
    output reg         fault_report_n_oe_n,
    output wire        irq,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    localparam PWM_TICK = `LCF_CLK_HZ / (`LCF_PWM_HZ * `LCF_PWM_RES);
    localparam NIN      = `LCF_IN_COUNT;
    localparam FULL     = `LCF_FADE_STEPS;

    reg              rst_meta;
    reg              rst_n;
    reg  [NIN-1:0]   in_meta;
    reg  [NIN-1:0]   in_sync;
    wire [NIN-1:0]   in_raw;
    wire [NIN-1:0]   in_filt;
    reg  [1:0]       flt_meta;
    reg  [1:0]       flt_sync;
    reg  [1:0]       tim_meta;
    reg  [1:0]       tim_sync;
    reg  [CNT_W-1:0] fade_step_len;
    reg  [CNT_W-1:0] step_cnt;
    reg              step_tick;
    reg  [9:0]       pwm_pre;
    reg  [7:0]       pwm_phase;
    reg  [3:0]       int_status;
    reg  [3:0]       int_enable;
    reg              fault_prev;
    wire             fault;
    wire             dim_active;
    wire             ext_mode;
    wire             pulse_mode;
    wire [1:0]       sw_filt;
    wire [1:0]       target;
    wire [1:0]       target_chg;
    wire [1:0]       ramp_done;
    wire [1:0]       lit;
    wire [11:0]      steps;
    wire [3:0]       events;

    function [8:0] gamma;
        input [5:0] s;
        reg   [31:0] t;
        begin
            t     = ({26'h0, s} * {26'h0, s} * 32'h100) / (`LCF_FADE_STEPS * `LCF_FADE_STEPS);
            gamma = t[8:0];
        end
    endfunction

    // reset release through two flip-flops
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    assign in_raw = {dim_input, dim_polarity_select, switch_style_select, dim_source_select,
                     backlight_on_input, switch_input_b, switch_input_a};

    // pin synchronisers
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_meta  <= {NIN{1'b0}};
            in_sync  <= {NIN{1'b0}};
            flt_meta <= 2'h0;
            flt_sync <= 2'h0;
            tim_meta <= 2'h0;
            tim_sync <= 2'h0;
        end else begin
            in_meta  <= in_raw;
            in_sync  <= in_meta;
            flt_meta <= {thermal_shutdown, string_short_detect};
            flt_sync <= flt_meta;
            tim_meta <= {fade_down_timing, fade_up_timing};
            tim_sync <= tim_meta;
        end
    end

    // debounce / deglitch filter per input
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi = gi + 1) begin : deb
            reg [CNT_W-1:0] cnt;
            reg             level;
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt   <= {CNT_W{1'b0}};
                    level <= 1'b0;
                end else if (in_sync[gi] == level) begin
                    cnt <= {CNT_W{1'b0}};
                end else if (cnt >= DEB_CYCLES[CNT_W-1:0] - 1'b1) begin
                    cnt   <= {CNT_W{1'b0}};
                    level <= in_sync[gi];
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
            assign in_filt[gi] = level;
        end
    endgenerate

    assign ext_mode   = in_filt[`LCF_IN_SOURCE];
    assign pulse_mode = in_filt[`LCF_IN_STYLE];
    assign dim_active = in_sync[`LCF_IN_DIM] ~^ in_filt[`LCF_IN_POLARITY];
    assign sw_filt    = {in_filt[`LCF_IN_SW_B], in_filt[`LCF_IN_SW_A]};
    assign fault      = flt_sync[0] | flt_sync[1];

    // fade step timer and pwm phase
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt  <= {CNT_W{1'b0}};
            step_tick <= 1'b0;
            pwm_pre   <= 10'h000;
            pwm_phase <= 8'h00;
        end else begin
            step_tick <= 1'b0;
            if (step_cnt + 1'b1 >= fade_step_len) begin
                step_cnt  <= {CNT_W{1'b0}};
                step_tick <= 1'b1;
            end else begin
                step_cnt <= step_cnt + 1'b1;
            end
            if (pwm_pre >= PWM_TICK[9:0] - 1'b1) begin
                pwm_pre   <= 10'h000;
                pwm_phase <= pwm_phase + 1'b1;
            end else begin
                pwm_pre <= pwm_pre + 1'b1;
            end
        end
    end

    // per main channel: enable state, target and fade ramp
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : ch
            reg       sw_prev;
            reg       en_state;
            reg       tgt_prev;
            reg       done;
            reg [5:0] step;
            wire      tgt;
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sw_prev  <= 1'b0;
                    en_state <= 1'b0;
                end else begin
                    sw_prev <= sw_filt[gi];
                    if (pulse_mode) begin
                        if (sw_prev && !sw_filt[gi])
                            en_state <= ~en_state;
                    end else begin
                        en_state <= sw_filt[gi];
                    end
                end
            end
            assign tgt = en_state | (~ext_mode & dim_active);
            always @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    step     <= 6'h00;
                    tgt_prev <= 1'b0;
                    done     <= 1'b0;
                end else begin
                    tgt_prev <= tgt;
                    done     <= 1'b0;
                    if (tgt && !tim_sync[0]) begin
                        step <= FULL[5:0];
                        done <= (step != `LCF_FADE_STEPS);
                    end else if (!tgt && !tim_sync[1]) begin
                        step <= 6'h00;
                        done <= (step != 6'h00);
                    end else if (step_tick && tgt && step != `LCF_FADE_STEPS) begin
                        step <= step + 1'b1;
                        done <= (step == `LCF_FADE_STEPS - 1);
                    end else if (step_tick && !tgt && step != 6'h00) begin
                        step <= step - 1'b1;
                        done <= (step == 6'h01);
                    end
                end
            end
            assign target[gi]         = tgt;
            assign target_chg[gi]     = tgt ^ tgt_prev;
            assign ramp_done[gi]      = done;
            assign steps[gi*6 +: 6]   = step;
            assign lit[gi]            = {1'b0, pwm_phase} < gamma(step);
        end
    endgenerate

    // output stage
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lamp_output_a       <= 1'b0;
            lamp_output_b       <= 1'b0;
            backlight_output    <= 1'b0;
            fault_report_n_oe_n <= 1'b1;
            fault_prev          <= 1'b0;
        end else begin
            lamp_output_a       <= lit[0] & (~ext_mode | dim_active);
            lamp_output_b       <= lit[1] & (~ext_mode | dim_active);
            backlight_output    <= in_filt[`LCF_IN_BACKLIGHT];
            fault_report_n_oe_n <= ~fault;
            fault_prev          <= fault;
        end
    end
    assign fault_report_n_out = 1'b0;

    // interrupt status: set wins over clear
    assign events = {|ramp_done, fault & ~fault_prev, target_chg};
    assign irq    = |(int_status & int_enable);

    // axi4-lite slave
    reg        aw_held;
    reg        w_held;
    reg [7:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    reg [31:0] rd_val;
    reg        rd_ok;
    wire       wr_go;
    wire [31:0] wmask;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_go         = aw_held & w_held & ~s_axi_bvalid;
    assign wmask         = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            fade_step_len <= FADE_CYCLES[CNT_W-1:0];
            int_enable    <= `LCF_INT_ENABLE_RST;
            int_status    <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            int_status <= int_status | events;
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `LCF_RESP_OKAY;
                case (aw_addr)
                    `LCF_ADDR_FADE_STEP:
                        fade_step_len <= ((w_data[CNT_W-1:0] & wmask[CNT_W-1:0]) |
                                          (fade_step_len & ~wmask[CNT_W-1:0]));
                    `LCF_ADDR_INT_ENABLE:
                        if (w_strb[0])
                            int_enable <= w_data[3:0];
                    `LCF_ADDR_INT_CLEAR:
                        if (w_strb[0])
                            int_status <= (int_status & ~w_data[3:0]) | events;
                    `LCF_ADDR_STATUS, `LCF_ADDR_INT_STATUS: ;
                    default:
                        s_axi_bresp <= `LCF_RESP_SLVERR;
                endcase
            end
        end
    end

    always @* begin
        rd_ok  = 1'b1;
        rd_val = 32'h00000000;
        case (s_axi_araddr)
            `LCF_ADDR_FADE_STEP:  rd_val[CNT_W-1:0] = fade_step_len;
            `LCF_ADDR_STATUS:     rd_val[17:0] = {steps, backlight_output, pulse_mode, ext_mode,
                                                  fault, target};
            `LCF_ADDR_INT_STATUS: rd_val[3:0] = int_status;
            `LCF_ADDR_INT_ENABLE: rd_val[3:0] = int_enable;
            `LCF_ADDR_INT_CLEAR:  rd_val = 32'h00000000;
            default:              rd_ok = 1'b0;
        endcase
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_ok ? `LCF_RESP_OKAY : `LCF_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ### bench/lcf_switch_model.sv
// wall switch and dim source model for the fade control bench
`timescale 1ns/1ps
module lcf_switch_model (
    input  wire ref_clk,
    input  wire pull_up,
    output wire switch_input_a,
    output wire switch_input_b,
    output reg  backlight_on_input,
    output reg  dim_input
);
    reg [1:0] hold;
    reg [1:0] val;
    // released pins sit at the pull level of the switch style
    assign switch_input_a = hold[0] ? val[0] : pull_up;
    assign switch_input_b = hold[1] ? val[1] : pull_up;
    initial begin
        hold = 2'h0;
        val = 2'h0;
        backlight_on_input = 1'b0;
        dim_input = 1'b0;
    end
    // i: 0,1 switches, 2 backlight, 3 dim
    task drive(input integer i, input h, input v);
        begin
            @(posedge ref_clk);
            if (i < 2) begin
                hold[i] <= h;
                val[i] <= v;
            end else if (i == 2)
                backlight_on_input <= v;
            else
                dim_input <= v;
        end
    endtask
    // low-going contact pulse
    task press(input integer i, input integer len);
        begin
            drive(i, 1'b1, 1'b0);
            repeat (len) @(posedge ref_clk);
            drive(i, 1'b0, 1'b0);
        end
    endtask
endmodule

// ### bench/lcf_top_props.sv
// port checker for the fade control block
`timescale 1ns/1ps
module lcf_top_props #(
    parameter DEB_CYCLES = 4
) (
    input wire        ref_clk, resetn, backlight_on_input, backlight_output,
    input wire        string_short_detect, thermal_shutdown, fault_report_n_out,
    input wire        fault_report_n_oe_n, irq, lamp_output_a, s_axi_awvalid,
    input wire        s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input wire        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire [31:0] s_axi_rdata
);
    reg [31:0] hi_cnt;
    reg [31:0] lo_cnt;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // steady cycles of the backlight pin
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hi_cnt <= 32'h0;
            lo_cnt <= 32'h0;
        end else begin
            hi_cnt <= backlight_on_input ? hi_cnt + 32'h1 : 32'h0;
            lo_cnt <= backlight_on_input ? 32'h0 : lo_cnt + 32'h1;
        end
    end
    fault_on_a: assert property (
        (string_short_detect || thermal_shutdown) [*3] |-> ##[0:4] !fault_report_n_oe_n)
        else $error("fault not reported");
    fault_off_a: assert property (
        (!string_short_detect && !thermal_shutdown) [*4] |-> ##[0:4] fault_report_n_oe_n)
        else $error("fault pin not released");
    drain_low_a: assert property (fault_report_n_out == 1'b0)
        else $error("open drain data not low");
    light_on_a: assert property (hi_cnt > DEB_CYCLES + 8 |-> backlight_output)
        else $error("backlight not on");
    light_off_a: assert property (lo_cnt > DEB_CYCLES + 8 |-> !backlight_output)
        else $error("backlight not off");
    write_resp_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("no write response");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during response");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("no read response");
    read_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    cover property ($rose(irq));
    cover property ($fell(fault_report_n_oe_n));
    cover property ($rose(lamp_output_a));
endmodule

// ### bench/tb_top.sv
// self-checking bench for the fade control block
`timescale 1ns/1ps
`include "lcf_consts.vh"
module tb_top;
    localparam DEB = 4;
    reg        ref_clk, resetn, dim_source_select, switch_style_select, dim_polarity_select;
    reg        fade_up_timing, fade_down_timing, string_short_detect, thermal_shutdown, sw_pull;
    reg        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg [7:0]  s_axi_awaddr, s_axi_araddr;
    reg [31:0] s_axi_wdata, rd;
    reg [3:0]  s_axi_wstrb;
    reg [1:0]  rs;
    reg [5:0]  s1, s2;
    wire       switch_input_a, switch_input_b, backlight_on_input, dim_input, lamp_output_a;
    wire       lamp_output_b, backlight_output, fault_report_n_out, fault_report_n_oe_n, irq;
    wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, lamps;
    wire [31:0] s_axi_rdata;
    wire       fault_report_n_in = fault_report_n_oe_n ? 1'b1 : fault_report_n_out;
    integer    bad_count, comparisons, i;
    assign lamps = {lamp_output_b, lamp_output_a};
    lcf_top #(.DEB_CYCLES(DEB), .FADE_CYCLES(4)) lcf_top_i (.ref_clk, .resetn, .switch_input_a,
        .switch_input_b, .backlight_on_input, .dim_input, .dim_source_select, .switch_style_select,
        .dim_polarity_select, .fade_up_timing, .fade_down_timing, .string_short_detect,
        .thermal_shutdown, .lamp_output_a, .lamp_output_b, .backlight_output, .fault_report_n_in,
        .fault_report_n_out, .fault_report_n_oe_n, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    lcf_switch_model lcf_switch_model_i (.ref_clk, .pull_up(sw_pull), .switch_input_a,
        .switch_input_b, .backlight_on_input, .dim_input);
    task check(input [63:0] seen, input [63:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                bad_count = bad_count + 1;
                $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wrap_up;
        begin
            if (bad_count == 0 && comparisons > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    function sel(input integer k);
        case (k)
            0: sel = s_axi_rvalid;
            1: sel = s_axi_bvalid;
            2: sel = backlight_output;
            3: sel = !backlight_output;
            4: sel = !fault_report_n_in;
            6: sel = s_axi_arready;
            default: sel = fault_report_n_in;
        endcase
    endfunction
    // bounded wait, judged at the falling edge before the sampling edge
    task await(input integer k);
        integer n;
        begin
            n = 0;
            @(negedge ref_clk);
            while (sel(k) !== 1'b1) begin
                @(negedge ref_clk);
                n = n + 1;
                if (n > 3000) begin
                    check(n, 0);
                    wrap_up;
                end
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        reg ta, tw;
        integer n;
        begin
            @(posedge ref_clk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
            {ta, tw, n} = 34'h0;
            while (!(ta && tw) && n < 3000) begin
                @(negedge ref_clk);
                ta = ta | (s_axi_awvalid & s_axi_awready);
                tw = tw | (s_axi_wvalid & s_axi_wready);
                @(posedge ref_clk);
                n = n + 1;
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
            end
            await(1);
            rs = s_axi_bresp;
            @(posedge ref_clk);
            s_axi_bready <= 1'b0;
        end
    endtask
    task rdr(input [7:0] a);
        begin
            @(posedge ref_clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            await(6);
            @(posedge ref_clk);
            s_axi_arvalid <= 1'b0;
            repeat (2) @(posedge ref_clk);
            s_axi_rready <= 1'b1;
            await(0);
            {rd, rs} = {s_axi_rdata, s_axi_rresp};
            @(posedge ref_clk);
            s_axi_rready <= 1'b0;
        end
    endtask
    // src, style, polarity, fade up, fade down
    task cfg(input [4:0] c);
        begin
            @(posedge ref_clk);
            {dim_source_select, switch_style_select, dim_polarity_select, fade_up_timing,
                fade_down_timing} <= c;
            repeat (DEB + 8) @(posedge ref_clk);
        end
    endtask
    task t_regs;
        begin
            rdr(`LCF_ADDR_INT_ENABLE);
            check({rs, rd}, 34'h0);
            rdr(8'h40);
            check({rs, rd}, {`LCF_RESP_SLVERR, 32'h0});
            wr(8'h40, 32'h5);
            check(rs, `LCF_RESP_SLVERR);
            wr(`LCF_ADDR_FADE_STEP, 32'h2);
            rdr(`LCF_ADDR_FADE_STEP);
            check(rd, 32'h2);
            rdr(`LCF_ADDR_INT_CLEAR);
            check(rd, 32'h0);
        end
    endtask
    task t_pins;
        begin
            lcf_switch_model_i.drive(2, 1'b1, 1'b1);
            await(2);
            check(backlight_output, 1'b1);
            repeat (DEB + 8) @(posedge ref_clk);
            lcf_switch_model_i.drive(2, 1'b1, 1'b0);
            await(3);
            check(backlight_output, 1'b0);
            for (i = 0; i < 2; i = i + 1) begin
                @(posedge ref_clk);
                {thermal_shutdown, string_short_detect} <= 2'h1 << i;
                await(4);
                check(fault_report_n_oe_n, 1'b0);
                @(posedge ref_clk);
                {thermal_shutdown, string_short_detect} <= 2'h0;
                await(5);
                check(fault_report_n_oe_n, 1'b1);
            end
        end
    endtask
    task t_modes;
        begin
            cfg(5'h04);
            for (i = 0; i < 2; i = i + 1) begin
                lcf_switch_model_i.drive(i, 1'b1, 1'b1);
                repeat (DEB + 8) @(posedge ref_clk);
                check(lamps, 2'h1 << i);
                lcf_switch_model_i.drive(i, 1'b1, 1'b0);
                repeat (DEB + 8) @(posedge ref_clk);
                check(lamps, 2'h0);
            end
            cfg(5'h14);
            lcf_switch_model_i.drive(0, 1'b1, 1'b1);
            lcf_switch_model_i.drive(3, 1'b1, 1'b1);
            repeat (DEB + 8) @(posedge ref_clk);
            check(lamp_output_a, 1'b1);
            lcf_switch_model_i.drive(3, 1'b1, 1'b0);
            repeat (DEB + 8) @(posedge ref_clk);
            check(lamp_output_a, 1'b0);
            cfg(5'h10);
            check(lamp_output_a, 1'b1);
            lcf_switch_model_i.drive(0, 1'b0, 1'b0);
            repeat (DEB + 8) @(posedge ref_clk);
            check(lamp_output_a, 1'b0);
            cfg(5'h04);
            lcf_switch_model_i.drive(3, 1'b1, 1'b1);
            repeat (DEB + 8) @(posedge ref_clk);
            check(lamps, 2'h3);
            lcf_switch_model_i.drive(3, 1'b1, 1'b0);
            repeat (DEB + 8) @(posedge ref_clk);
            check(lamps, 2'h0);
        end
    endtask
    task t_pulse;
        begin
            cfg(5'h0F);
            sw_pull <= 1'b1;
            repeat (DEB + 8) @(posedge ref_clk);
            wr(`LCF_ADDR_INT_CLEAR, 32'hF);
            wr(`LCF_ADDR_INT_ENABLE, 32'h1);
            lcf_switch_model_i.press(0, 2);
            repeat (DEB + 8) @(posedge ref_clk);
            check(irq, 1'b0);
            lcf_switch_model_i.press(0, DEB + 4);
            repeat (8) @(posedge ref_clk);
            rdr(`LCF_ADDR_STATUS);
            s1 = rd[11:6];
            check({rd[0], irq, s1 > 6'h0 && s1 < 6'h3F}, 3'h7);
            wr(`LCF_ADDR_INT_ENABLE, 32'h0);
            check(irq, 1'b0);
            wr(`LCF_ADDR_INT_ENABLE, 32'h1);
            check(irq, 1'b1);
            wr(`LCF_ADDR_INT_CLEAR, 32'h1);
            check(irq, 1'b0);
            lcf_switch_model_i.press(0, DEB + 4);
            rdr(`LCF_ADDR_STATUS);
            s2 = rd[11:6];
            repeat (10) @(posedge ref_clk);
            rdr(`LCF_ADDR_STATUS);
            check({rd[0], rd[11:6] < s2, s2 > 6'h0}, 3'h3);
            repeat (200) @(posedge ref_clk);
            rdr(`LCF_ADDR_STATUS);
            check({rd[11:6], lamp_output_a}, 7'h0);
            lcf_switch_model_i.press(0, DEB + 4);
            repeat (200) @(posedge ref_clk);
            rdr(`LCF_ADDR_STATUS);
            check({rd[11:6], lamp_output_a}, {6'h3F, 1'b1});
        end
    endtask
    initial begin
        {resetn, dim_source_select, switch_style_select, dim_polarity_select, fade_up_timing,
            fade_down_timing, string_short_detect, thermal_shutdown, sw_pull, s_axi_awvalid,
            s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 14'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        {bad_count, comparisons} = 64'h0;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_regs;
        t_pins;
        t_modes;
        t_pulse;
        wrap_up;
    end
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
endmodule
bind lcf_top lcf_top_props #(.DEB_CYCLES(DEB_CYCLES)) lcf_top_props_i (.ref_clk, .resetn,
    .backlight_on_input, .backlight_output, .string_short_detect, .thermal_shutdown,
    .fault_report_n_out, .fault_report_n_oe_n, .irq, .lamp_output_a, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
